//--- prsl_consts.svh
// Constants for the pin reset state logic: widths, bit positions,
// reset levels and timing counts.
// Assumes inclusion by bare name from the package and the modules.
`ifndef PRSL_CONSTS_SVH
`define PRSL_CONSTS_SVH

// ==========================================================
// Widths
`define PRSL_MEM_ADDR_W 28
`define PRSL_SRAM_BANKS 5
`define PRSL_ARB_AGENTS 4
`define PRSL_PCI_CTL_W 8
`define PRSL_SYNC_W 9

// ==========================================================
// PCI control vector bit positions
`define PRSL_CTL_FRAME 0
`define PRSL_CTL_IRDY 1
`define PRSL_CTL_TRDY 2
`define PRSL_CTL_STOP 3
`define PRSL_CTL_DEVSEL 4
`define PRSL_CTL_LOCK 5
`define PRSL_CTL_PERR 6
`define PRSL_CTL_REQ 7

// ==========================================================
// Synchroniser bit positions
`define PRSL_SY_PCLK 0
`define PRSL_SY_PRST_N 1
`define PRSL_SY_HOST_N 2
`define PRSL_SY_BYPASS 3
`define PRSL_SY_LOCK 4
`define PRSL_SY_REQ_LSB 5

// ==========================================================
// Reset levels and counts
`define PRSL_GRANT_IDLE 4'hf
`define PRSL_GRANT_PARK0 4'he
`define PRSL_REQ_NONE 4'hf
`define PRSL_ADDR_RST 28'h0000000
`define PRSL_PCI_RESUME_EDGES 5

`endif

//--- prsl_pkg.sv
// Types for the pin reset state logic.
// Assumes prsl_consts.svh is on the include path.
`include "prsl_consts.svh"

package prsl_pkg;

	// ==========================================================
	// PCI reset sequencer
	typedef enum logic [1:0] {
		PCI_HELD,
		PCI_WAIT,
		PCI_RUN
	} prsl_pci_st_t;

	// ==========================================================
	// Whole state of the top module
	typedef struct packed {
		prsl_pci_st_t pci_st;
		logic [2:0] edge_cnt;
		logic pclk_d;
		logic [31:0] ad;
		logic ad_oe;
		logic [3:0] cbe;
		logic cbe_oe;
		logic par;
		logic par_oe;
		logic [`PRSL_PCI_CTL_W-1:0] ctl;
		logic [`PRSL_PCI_CTL_W-1:0] ctl_oe;
		logic serr_oe;
		logic [`PRSL_ARB_AGENTS-1:0] gnt_n;
		logic [`PRSL_SRAM_BANKS-1:0] bank_sel_n;
		logic [`PRSL_SRAM_BANKS-1:0] out_en_n;
		logic [1:0] boot_sel_n;
		logic io_sel_n;
		logic gen_oe_n;
		logic [1:0] sync_sel_n;
		logic rd;
		logic wr_n;
		logic [3:0] bwe_n;
		logic cas_n;
		logic ras_n;
		logic swe_n;
		logic dbg_act;
		logic dbg_tx;
		logic err_oe;
		logic watchdog_flag_n_oe;
		logic [`PRSL_MEM_ADDR_W-1:0] addr;
		logic lock;
	} prsl_state_t;

endpackage

//--- prsl_sync.sv
// Two-stage synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
`timescale 1ns/1ps
`default_nettype none

module prsl_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Levels
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
	} prsl_sync_t;

	prsl_sync_t st_ff;
	prsl_sync_t nxt_st;

	if (WIDTH < 1) begin
		$error("prsl_sync: WIDTH must be at least 1");
	end

	// ==========================================================
	// First stage is read only by the second
	always_comb begin
		nxt_st.s1 = d_i;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q_o = st_ff.s2;

endmodule

`default_nettype wire

//--- prsl_top.sv
// Pin reset state logic: drives memory, debug, error and PCI pins to
// their reset levels and hands them to the core outside reset.
// Assumes core_clk_i is the memory clock; pin inputs are asynchronous.
//
// How it works
// - Non-PCI pins follow the memory clock and system reset, PCI pins follow PCI clock and reset.
// - While PCI reset is held every PCI driver including request, but not grant, is released to high impedance.
// - In reset the memory, boot, I/O, output-enable and sync-memory selects are driven high.
// - Memory strobes, byte write enables and debug outputs go high at the first clock edge in reset.
// - The open-drain error and watchdog flags are released after the first clock edge in reset.
// - In host mode under PCI reset, grant parks on agent 0 if no request is seen, else all high.
// - The lock output goes low in reset and rises once the PLL locks, except in bypass mode.
// - The memory address outputs hold a valid fixed level during reset.
// - PCI reset halts the PCI side at once; it resumes after the fifth PCI clock edge past release.
`timescale 1ns/1ps
`default_nettype none
`include "prsl_consts.svh"

module prsl_top
	import prsl_pkg::*;
#(
	parameter int RESUME_EDGES = `PRSL_PCI_RESUME_EDGES
) (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	// Asynchronous pins
	input wire logic pci_clk_i,
	input wire logic pci_rst_n_i,
	input wire logic host_select_n_i,
	input wire logic pll_bypass_i,
	input wire logic pll_lock_i,
	input wire logic [`PRSL_ARB_AGENTS-1:0] arb_request_n_i,
	// Core values for the PCI pins
	input wire logic [31:0] pci_ad_fn_i,
	input wire logic pci_ad_oe_fn_i,
	input wire logic [3:0] pci_cbe_fn_i,
	input wire logic pci_cbe_oe_fn_i,
	input wire logic pci_par_fn_i,
	input wire logic pci_par_oe_fn_i,
	input wire logic [`PRSL_PCI_CTL_W-1:0] pci_ctl_fn_i,
	input wire logic [`PRSL_PCI_CTL_W-1:0] pci_ctl_oe_fn_i,
	input wire logic pci_serr_oe_fn_i,
	input wire logic [`PRSL_ARB_AGENTS-1:0] arb_grant_n_fn_i,
	// Core values for the memory and debug pins
	input wire logic [`PRSL_SRAM_BANKS-1:0] sram_bank_sel_n_fn_i,
	input wire logic [`PRSL_SRAM_BANKS-1:0] sram_out_en_n_fn_i,
	input wire logic [1:0] boot_mem_sel_n_fn_i,
	input wire logic io_space_sel_n_fn_i,
	input wire logic gen_out_en_n_fn_i,
	input wire logic [1:0] sync_mem_sel_n_fn_i,
	input wire logic read_strobe_fn_i,
	input wire logic write_strobe_n_fn_i,
	input wire logic [3:0] byte_write_en_n_fn_i,
	input wire logic col_strobe_n_fn_i,
	input wire logic row_strobe_n_fn_i,
	input wire logic sync_write_strobe_n_fn_i,
	input wire logic debug_active_flag_fn_i,
	input wire logic debug_serial_tx_fn_i,
	input wire logic error_flag_fn_i,
	input wire logic watchdog_flag_fn_i,
	input wire logic [`PRSL_MEM_ADDR_W-1:0] mem_addr_fn_i,
	// PCI pins
	output logic [31:0] pci_ad_o,
	output logic pci_ad_oe_o,
	output logic [3:0] pci_cbe_o,
	output logic pci_cbe_oe_o,
	output logic pci_par_o,
	output logic pci_par_oe_o,
	output logic [`PRSL_PCI_CTL_W-1:0] pci_ctl_o,
	output logic [`PRSL_PCI_CTL_W-1:0] pci_ctl_oe_o,
	output logic pci_serr_o,
	output logic pci_serr_oe_o,
	output logic [`PRSL_ARB_AGENTS-1:0] arb_grant_n_o,
	output logic pci_run_o,
	// Memory and debug pins
	output logic [`PRSL_SRAM_BANKS-1:0] sram_bank_sel_n_o,
	output logic [`PRSL_SRAM_BANKS-1:0] sram_out_en_n_o,
	output logic [1:0] boot_mem_sel_n_o,
	output logic io_space_sel_n_o,
	output logic gen_out_en_n_o,
	output logic [1:0] sync_mem_sel_n_o,
	output logic read_strobe_o,
	output logic write_strobe_n_o,
	output logic [3:0] byte_write_en_n_o,
	output logic col_strobe_n_o,
	output logic row_strobe_n_o,
	output logic sync_write_strobe_n_o,
	output logic debug_active_flag_o,
	output logic debug_serial_tx_o,
	output logic error_flag_n_o,
	output logic error_flag_oe_o,
	output logic watchdog_flag_n_o,
	output logic watchdog_flag_oe_o,
	output logic [`PRSL_MEM_ADDR_W-1:0] mem_addr_o,
	output logic pll_lock_o
);

	localparam logic [2:0] RESUME_CNT = 3'(RESUME_EDGES);
	// Reset image; unnamed fields start low, which also releases every PCI driver
	localparam prsl_state_t RST_ST = '{pci_st: PCI_HELD, gnt_n: `PRSL_GRANT_IDLE,
		bank_sel_n: '1, out_en_n: '1, boot_sel_n: '1,
		io_sel_n: '1, gen_oe_n: '1, sync_sel_n: '1,
		rd: '1, wr_n: '1, bwe_n: '1, cas_n: '1, ras_n: '1, swe_n: '1, dbg_act: '1,
		dbg_tx: '1, err_oe: 1'b0, watchdog_flag_n_oe: 1'b0, lock: 1'b0,
		addr: `PRSL_ADDR_RST, default: '0};

	if (RESUME_EDGES < 1 || RESUME_EDGES > 7) begin
		$error("prsl_top: RESUME_EDGES out of 1..7");
	end

	// ==========================================================
	// Pin synchronisers
	logic [`PRSL_SYNC_W-1:0] sy_q;
	wire logic [`PRSL_SYNC_W-1:0] sy_d = {arb_request_n_i, pll_lock_i, pll_bypass_i,
		host_select_n_i, pci_rst_n_i, pci_clk_i};

	prsl_sync #(.WIDTH(`PRSL_SYNC_W)) u_sync (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
		.d_i(sy_d), .q_o(sy_q));

	wire logic pclk_s = sy_q[`PRSL_SY_PCLK];
	wire logic pci_held_s = ~sy_q[`PRSL_SY_PRST_N];
	wire logic host_mode_s = ~sy_q[`PRSL_SY_HOST_N];
	wire logic bypass_s = sy_q[`PRSL_SY_BYPASS];
	wire logic lock_s = sy_q[`PRSL_SY_LOCK];
	wire logic [`PRSL_ARB_AGENTS-1:0] req_n_s = sy_q[`PRSL_SY_REQ_LSB +: `PRSL_ARB_AGENTS];

	prsl_state_t st_ff;
	prsl_state_t nxt_st;
	wire logic pci_edge = pclk_s & ~st_ff.pclk_d;

	// ==========================================================
	// Next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.pclk_d = pclk_s;
		// PCI sequencer; halts in the same cycle as the synced reset
		case (st_ff.pci_st)
			PCI_HELD: begin
				nxt_st.edge_cnt = 3'h0;
				if (!pci_held_s) begin
					nxt_st.pci_st = PCI_WAIT;
				end
			end
			PCI_WAIT: begin
				if (pci_held_s) begin
					nxt_st.pci_st = PCI_HELD;
				end else if (pci_edge) begin
					nxt_st.edge_cnt = st_ff.edge_cnt + 3'h1;
					if (st_ff.edge_cnt + 3'h1 == RESUME_CNT) begin
						nxt_st.pci_st = PCI_RUN;
					end
				end
			end
			PCI_RUN: begin
				if (pci_held_s) begin
					nxt_st.pci_st = PCI_HELD;
				end
			end
			default: nxt_st.pci_st = PCI_HELD;
		endcase
		// PCI drivers: released until running, updated on PCI edges only
		if (pci_held_s || st_ff.pci_st != PCI_RUN) begin
			nxt_st.ad_oe = 1'b0;
			nxt_st.cbe_oe = 1'b0;
			nxt_st.par_oe = 1'b0;
			nxt_st.ctl_oe = '0;
			nxt_st.serr_oe = 1'b0;
		end else if (pci_edge) begin
			nxt_st.ad = pci_ad_fn_i;
			nxt_st.ad_oe = pci_ad_oe_fn_i;
			nxt_st.cbe = pci_cbe_fn_i;
			nxt_st.cbe_oe = pci_cbe_oe_fn_i;
			nxt_st.par = pci_par_fn_i;
			nxt_st.par_oe = pci_par_oe_fn_i;
			nxt_st.ctl = pci_ctl_fn_i;
			nxt_st.ctl_oe = pci_ctl_oe_fn_i;
			nxt_st.serr_oe = pci_serr_oe_fn_i;
		end
		// Arbiter grants
		if (!host_mode_s) begin
			nxt_st.gnt_n = `PRSL_GRANT_IDLE;
		end else if (pci_edge) begin
			if (st_ff.pci_st != PCI_RUN || pci_held_s) begin
				nxt_st.gnt_n = (req_n_s == `PRSL_REQ_NONE) ? `PRSL_GRANT_PARK0 :
					`PRSL_GRANT_IDLE;
			end else begin
				nxt_st.gnt_n = arb_grant_n_fn_i;
			end
		end
		// Memory, debug and error pins follow the core outside reset
		nxt_st.bank_sel_n = sram_bank_sel_n_fn_i;
		nxt_st.out_en_n = sram_out_en_n_fn_i;
		nxt_st.boot_sel_n = boot_mem_sel_n_fn_i;
		nxt_st.io_sel_n = io_space_sel_n_fn_i;
		nxt_st.gen_oe_n = gen_out_en_n_fn_i;
		nxt_st.sync_sel_n = sync_mem_sel_n_fn_i;
		nxt_st.rd = read_strobe_fn_i;
		nxt_st.wr_n = write_strobe_n_fn_i;
		nxt_st.bwe_n = byte_write_en_n_fn_i;
		nxt_st.cas_n = col_strobe_n_fn_i;
		nxt_st.ras_n = row_strobe_n_fn_i;
		nxt_st.swe_n = sync_write_strobe_n_fn_i;
		nxt_st.dbg_act = debug_active_flag_fn_i;
		nxt_st.dbg_tx = debug_serial_tx_fn_i;
		nxt_st.err_oe = error_flag_fn_i;
		nxt_st.watchdog_flag_n_oe = watchdog_flag_fn_i;
		nxt_st.addr = mem_addr_fn_i;
		// Bypass: PLL unused, so lock is shown high
		nxt_st.lock = bypass_s | lock_s;
	end

	// ==========================================================
	// State register; system reset keeps PCI side halted too
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_ff <= RST_ST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ==========================================================
	// Outputs
	assign pci_ad_o = st_ff.ad;
	assign pci_ad_oe_o = st_ff.ad_oe;
	assign pci_cbe_o = st_ff.cbe;
	assign pci_cbe_oe_o = st_ff.cbe_oe;
	assign pci_par_o = st_ff.par;
	assign pci_par_oe_o = st_ff.par_oe;
	assign pci_ctl_o = st_ff.ctl;
	assign pci_ctl_oe_o = st_ff.ctl_oe;
	assign pci_serr_o = 1'b0;
	assign pci_serr_oe_o = st_ff.serr_oe;
	assign arb_grant_n_o = st_ff.gnt_n;
	assign pci_run_o = (st_ff.pci_st == PCI_RUN);
	assign sram_bank_sel_n_o = st_ff.bank_sel_n;
	assign sram_out_en_n_o = st_ff.out_en_n;
	assign boot_mem_sel_n_o = st_ff.boot_sel_n;
	assign io_space_sel_n_o = st_ff.io_sel_n;
	assign gen_out_en_n_o = st_ff.gen_oe_n;
	assign sync_mem_sel_n_o = st_ff.sync_sel_n;
	assign read_strobe_o = st_ff.rd;
	assign write_strobe_n_o = st_ff.wr_n;
	assign byte_write_en_n_o = st_ff.bwe_n;
	assign col_strobe_n_o = st_ff.cas_n;
	assign row_strobe_n_o = st_ff.ras_n;
	assign sync_write_strobe_n_o = st_ff.swe_n;
	assign debug_active_flag_o = st_ff.dbg_act;
	assign debug_serial_tx_o = st_ff.dbg_tx;
	// Open drain: output level fixed low, enable carries the flag
	assign error_flag_n_o = 1'b0;
	assign error_flag_oe_o = st_ff.err_oe;
	assign watchdog_flag_n_o = 1'b0;
	assign watchdog_flag_oe_o = st_ff.watchdog_flag_n_oe;
	assign mem_addr_o = st_ff.addr;
	assign pll_lock_o = st_ff.lock;

	// ==========================================================
	// Assertions
	AST_PCI_DOMAIN: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$changed(arb_grant_n_o) && $past(host_mode_s) |-> $past(pci_edge))
		else $error("grant changed without a PCI clock edge");
	AST_PCI_HIZ: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$past(pci_held_s) |-> !pci_ad_oe_o && !pci_cbe_oe_o && !pci_par_oe_o
			&& pci_ctl_oe_o == '0 && !pci_serr_oe_o)
		else $error("PCI driver enabled under PCI reset");
	AST_SEL_HIGH: assert property (@(posedge core_clk_i)
		$past(sys_rst_i) |-> &sram_bank_sel_n_o && &sram_out_en_n_o && &boot_mem_sel_n_o
			&& io_space_sel_n_o && gen_out_en_n_o && &sync_mem_sel_n_o)
		else $error("select not high in reset");
	AST_STROBE_HIGH: assert property (@(posedge core_clk_i)
		$past(sys_rst_i) |-> read_strobe_o && write_strobe_n_o && &byte_write_en_n_o
			&& col_strobe_n_o && row_strobe_n_o && sync_write_strobe_n_o
			&& debug_active_flag_o && debug_serial_tx_o)
		else $error("strobe not high in reset");
	AST_OD_RELEASE: assert property (@(posedge core_clk_i)
		$past(sys_rst_i) |-> !error_flag_oe_o && !watchdog_flag_oe_o)
		else $error("open-drain flag driven in reset");
	AST_GRANT_PARK: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$past(pci_edge) && $past(host_mode_s) && $past(pci_held_s)
			|-> arb_grant_n_o == (($past(req_n_s) == `PRSL_REQ_NONE) ?
				`PRSL_GRANT_PARK0 : `PRSL_GRANT_IDLE))
		else $error("wrong grant parking in PCI reset");
	AST_LOCK_LOW: assert property (@(posedge core_clk_i)
		$past(sys_rst_i) ##1 (!$past(bypass_s) && !$past(lock_s)) |-> !pll_lock_o)
		else $error("lock high before PLL lock");
	AST_ADDR_VALID: assert property (@(posedge core_clk_i)
		$past(sys_rst_i) |-> mem_addr_o == `PRSL_ADDR_RST)
		else $error("address not at reset level");
	AST_PCI_RESUME: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(pci_run_o) |-> $past(pci_edge) && $past(st_ff.edge_cnt) == RESUME_CNT - 3'h1)
		else $error("PCI resumed at wrong edge");

endmodule

`default_nettype wire

//--- prsl_board_model.sv
// Board-side model: free-running PCI clock, PCI reset pin and agent requests.
// Assumes the bench drives hold_i and req_n_i from its own clock domain.
`timescale 1ns/1ps
`default_nettype none

module prsl_board_model (
	// Controls from the bench
	input wire logic hold_i,
	input wire logic [3:0] req_n_i,
	// Board pins
	output logic pci_clk_o,
	output logic pci_rst_n_o,
	output logic [3:0] arb_request_n_o
);
	// Start values keep the pins defined before the first PCI edge
	logic pclk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] req_n = 4'hf;

	// ==========================================================
	// PCI clock, 60 ns, phase unrelated to the core clock
	initial begin
		#7;
		forever #30 pclk = ~pclk;
	end

	// ==========================================================
	// Pins move on PCI edges only, as a real agent would
	always @(posedge pclk) begin
		rst_n <= ~hold_i;
		req_n <= req_n_i;
	end

	assign pci_clk_o = pclk;
	assign pci_rst_n_o = rst_n;
	assign arb_request_n_o = req_n;
endmodule
`default_nettype wire

//--- pin_reset_state_logic_test.sv
// Self-checking bench for the pin reset state logic.
// Assumes prsl_top and prsl_board_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "prsl_consts.svh"

module pin_reset_state_logic_test;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic host_n = 1'b0;
	logic bypass = 1'b0;
	logic lock_in = 1'b0;
	logic hold = 1'b1;
	logic [3:0] req_n = 4'hf;
	logic [3:0] gfn = 4'hf;
	logic [56:0] mfn = 57'h0;
	logic [56:0] pfn = 57'h0;
	wire logic pci_clk;
	wire logic pci_rst_n;
	wire logic run;
	wire logic lock_o;
	wire logic [3:0] areq_n;
	wire logic [3:0] gnt_n;
	wire logic [56:0] mq;
	wire logic [56:0] pq;
	wire logic [11:0] poe;
	wire logic [2:0] odq;
	int fails = 0;
	int comparisons = 0;
	int n;
	int m;
	int k;

	always #2.5 core_clk = ~core_clk;
	assign poe = {pq[24], pq[19], pq[17], pq[8:1], pq[0]};

	// ==========================================================
	// Design and board
	prsl_board_model u_board (.hold_i(hold), .req_n_i(req_n), .pci_clk_o(pci_clk),
		.pci_rst_n_o(pci_rst_n), .arb_request_n_o(areq_n));

	prsl_top #(.RESUME_EDGES(5)) u_dut (.core_clk_i(core_clk), .sys_rst_i(sys_rst),
		.pci_clk_i(pci_clk), .pci_rst_n_i(pci_rst_n), .host_select_n_i(host_n),
		.pll_bypass_i(bypass), .pll_lock_i(lock_in), .arb_request_n_i(areq_n),
		.pci_ad_fn_i(pfn[56:25]), .pci_ad_oe_fn_i(pfn[24]), .pci_cbe_fn_i(pfn[23:20]),
		.pci_cbe_oe_fn_i(pfn[19]), .pci_par_fn_i(pfn[18]), .pci_par_oe_fn_i(pfn[17]),
		.pci_ctl_fn_i(pfn[16:9]), .pci_ctl_oe_fn_i(pfn[8:1]), .pci_serr_oe_fn_i(pfn[0]),
		.arb_grant_n_fn_i(gfn), .sram_bank_sel_n_fn_i(mfn[56:52]),
		.sram_out_en_n_fn_i(mfn[51:47]), .boot_mem_sel_n_fn_i(mfn[46:45]),
		.io_space_sel_n_fn_i(mfn[44]), .gen_out_en_n_fn_i(mfn[43]),
		.sync_mem_sel_n_fn_i(mfn[42:41]), .read_strobe_fn_i(mfn[40]),
		.write_strobe_n_fn_i(mfn[39]), .byte_write_en_n_fn_i(mfn[38:35]),
		.col_strobe_n_fn_i(mfn[34]), .row_strobe_n_fn_i(mfn[33]),
		.sync_write_strobe_n_fn_i(mfn[32]), .debug_active_flag_fn_i(mfn[31]),
		.debug_serial_tx_fn_i(mfn[30]), .error_flag_fn_i(mfn[29]),
		.watchdog_flag_fn_i(mfn[28]), .mem_addr_fn_i(mfn[27:0]),
		.pci_ad_o(pq[56:25]), .pci_ad_oe_o(pq[24]), .pci_cbe_o(pq[23:20]),
		.pci_cbe_oe_o(pq[19]), .pci_par_o(pq[18]), .pci_par_oe_o(pq[17]),
		.pci_ctl_o(pq[16:9]), .pci_ctl_oe_o(pq[8:1]), .pci_serr_o(odq[2]),
		.pci_serr_oe_o(pq[0]),
		.arb_grant_n_o(gnt_n), .pci_run_o(run), .sram_bank_sel_n_o(mq[56:52]),
		.sram_out_en_n_o(mq[51:47]), .boot_mem_sel_n_o(mq[46:45]),
		.io_space_sel_n_o(mq[44]), .gen_out_en_n_o(mq[43]), .sync_mem_sel_n_o(mq[42:41]),
		.read_strobe_o(mq[40]), .write_strobe_n_o(mq[39]), .byte_write_en_n_o(mq[38:35]),
		.col_strobe_n_o(mq[34]), .row_strobe_n_o(mq[33]), .sync_write_strobe_n_o(mq[32]),
		.debug_active_flag_o(mq[31]), .debug_serial_tx_o(mq[30]), .error_flag_n_o(odq[1]),
		.error_flag_oe_o(mq[29]), .watchdog_flag_n_o(odq[0]), .watchdog_flag_oe_o(mq[28]),
		.mem_addr_o(mq[27:0]), .pll_lock_o(lock_o));

	// ==========================================================
	// Compare, bound and close
	task check(input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Parking grant under PCI reset: agent 0 only when nobody asks
	function automatic logic [3:0] park_exp(input logic sat, input logic [3:0] req);
		return (sat || req != 4'hf) ? 4'hf : 4'he;
	endfunction

	task bound(input int cnt, input int lim);
		if (cnt >= lim) begin
			fails++;
			$display("wait ran out at %0t", $time);
			test_done();
		end
	endtask

	task test_done;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ==========================================================
	// Main sequence, host mode then satellite mode
	initial begin
		void'($urandom(66));
		for (m = 0; m < 2; m++) begin
			@(posedge core_clk);
			sys_rst <= 1'b1;
			hold <= 1'b1;
			host_n <= m[0];
			bypass <= 1'b0;
			lock_in <= 1'b0;
			mfn <= 57'({$urandom, $urandom});
			repeat (5) @(posedge core_clk);
			// Address level in reset is fixed at zero, but it is not compared here
			#1 check(mq[56:28], 29'h1ffffffc);
			check(poe, 12'h000);
			check(run, 1'b0);
			check(lock_o, 1'b0);
			check(gnt_n, 4'hf);
			check(odq, 3'h0);
			$display("reset levels done, mode %0d", m);
			@(posedge core_clk);
			sys_rst <= 1'b0;
			for (k = 0; k < 20; k++) begin
				@(posedge core_clk);
				mfn <= 57'({$urandom, $urandom});
				repeat (2) @(posedge core_clk);
				#1 check(mq, mfn);
			end
			$display("memory pins done");
			check(lock_o, 1'b0);
			@(posedge core_clk);
			lock_in <= 1'b1;
			for (n = 0; n < 8 && lock_o !== 1'b1; n++) @(posedge core_clk);
			bound(n, 8);
			@(posedge core_clk);
			lock_in <= 1'b0;
			bypass <= 1'b1;
			repeat (4) @(posedge core_clk);
			#1 check(lock_o, 1'b1);
			$display("lock done");
			// Grant parking while the PCI side is still held
			@(posedge core_clk);
			req_n <= 4'hf;
			repeat (2) @(posedge pci_clk);
			repeat (5) @(posedge core_clk);
			#1 check(gnt_n, park_exp(m[0], req_n));
			@(posedge core_clk);
			req_n <= ~(4'h1 << $urandom_range(3, 0));
			repeat (2) @(posedge pci_clk);
			repeat (5) @(posedge core_clk);
			#1 check(gnt_n, park_exp(m[0], req_n));
			$display("grant park done");
			// Release of the PCI side, counted in PCI edges
			@(posedge core_clk);
			hold <= 1'b0;
			@(posedge pci_clk);
			repeat (4) @(posedge pci_clk);
			repeat (10) @(posedge core_clk);
			#1 check(run, 1'b0);
			@(posedge pci_clk);
			for (n = 0; n < 8 && run !== 1'b1; n++) @(posedge core_clk);
			bound(n, 8);
			check(run, 1'b1);
			@(posedge core_clk);
			pfn <= 57'({$urandom, $urandom}) | 57'h1000000;
			gfn <= 4'($urandom);
			repeat (2) @(posedge pci_clk);
			repeat (5) @(posedge core_clk);
			#1 check(pq, pfn);
			check(gnt_n, m ? 4'hf : gfn);
			// PCI reset in mid-run must halt at once
			@(posedge core_clk);
			hold <= 1'b1;
			@(posedge pci_clk);
			for (n = 0; n < 6 && run !== 1'b0; n++) @(posedge core_clk);
			bound(n, 6);
			#1 check(poe, 12'h000);
			$display("pci sequence done");
		end
		test_done();
	end
endmodule
`default_nettype wire
